// >>> dv/stf_drive_model.sv
`timescale 1ns/1ps
// Drive stage takes torque per sample; sensor reports error and motion
module stf_drive_model (
   input  wire logic               core_clk_i, // Servo clock
   input  wire logic               nrst_i,     // Sync reset, active low
   input  wire logic               sample_i,   // Sample strobe
   input  wire logic signed [23:0] torque_i,   // Torque to apply
   input  wire logic signed [31:0] err_set_i,  // Error the scene should show
   output logic signed [31:0]      pos_err_o,  // Sensed position error
   output logic                    moving_o,   // Motor not stopped
   output logic signed [23:0]      applied_o   // Torque in force
);
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         pos_err_o <= 32'sh0;
         moving_o  <= 1'b0;
         applied_o <= 24'sh0;
      end else if (sample_i) begin
         applied_o <= torque_i;
         moving_o  <= (err_set_i != pos_err_o);
         pos_err_o <= err_set_i;
      end
   end
endmodule // stf_drive_model

// >>> dv/stf_tuning_chk.sv
`timescale 1ns/1ps
module stf_tuning_chk (
   input  wire logic                   core_clk_i,              // Clock
   input  wire logic                   nrst_i,                  // Reset
   input  wire logic                   sample_i,                // Sample strobe
   input  wire logic signed [31:0]     pos_dev_i,               // Deviation in
   input  wire logic signed [31:0]     pos_dev_o,               // Deviation out
   input  wire logic                   dead_band_we_i,          // Write strobe
   input  wire logic                   password_ok_i,           // Password
   input  wire logic                   dead_band_reject_o,      // Refusal
   input  wire logic [11:0]            position_dead_band_o,    // Dead band
   input  wire logic [21:0]            gain_switch_threshold_i, // Threshold
   input  wire stf_pkg::stf_gain_set_t run_gains_i,             // Run gains
   input  wire logic                   motor_moving_i,          // Moving
   input  wire logic                   internal_motion_i,       // Internal pulses
   input  wire logic signed [31:0]     pos_err_i,               // Error
   input  wire stf_pkg::stf_gain_set_t gains_o,                 // Gains out
   input  wire logic                   gain_state_monitor_o     // Monitor
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   logic [31:0] dev_abs;
   logic [32:0] dev_twice;
   logic [31:0] err_abs;
   assign dev_abs   = pos_dev_i[31] ? 32'(-pos_dev_i) : 32'(pos_dev_i);
   assign dev_twice = {dev_abs, 1'b0};
   assign err_abs   = pos_err_i[31] ? 32'(-pos_err_i) : 32'(pos_err_i);
   // Run gains are latched one sample early, so a prior sample with steady inputs is needed
   sequence s_thr_off;
      sample_i ##1 (!sample_i && gain_switch_threshold_i == 22'h000000 && $stable(run_gains_i)) [*3]
         ##1 (sample_i && gain_switch_threshold_i == 22'h000000 && $stable(run_gains_i));
   endsequence
   sequence s_motion; (motor_moving_i || internal_motion_i) [*2] ##0 sample_i; endsequence
   sequence s_err_big;
      (gain_switch_threshold_i != 22'h000000 && err_abs >= {10'h000, gain_switch_threshold_i}) [*2] ##0 sample_i;
   endsequence
   property p_reject; dead_band_we_i && !password_ok_i |=> dead_band_reject_o; endproperty
   property p_accept; dead_band_we_i && password_ok_i |=> !dead_band_reject_o; endproperty
   property p_hold; !sample_i |=> $stable(position_dead_band_o) && $stable(gains_o) && $stable(gain_state_monitor_o);
   endproperty
   property p_thr_off; s_thr_off |=> gain_state_monitor_o && gains_o == run_gains_i; endproperty
   property p_motion; s_motion |=> gain_state_monitor_o; endproperty
   property p_err_big; s_err_big |=> gain_state_monitor_o; endproperty
   property p_db_zero;
      sample_i && !dead_band_we_i && dev_twice < {21'h0, position_dead_band_o} |=> pos_dev_o == 32'sh0;
   endproperty
   property p_db_pass;
      sample_i && !dead_band_we_i && dev_twice >= {21'h0, position_dead_band_o} |=> pos_dev_o == $past(pos_dev_i);
   endproperty
   a_reject:  assert property (p_reject) else $error("refused write gave no reject pulse");
   a_accept:  assert property (p_accept) else $error("accepted write was rejected");
   a_hold:    assert property (p_hold) else $error("setting changed between samples");
   a_thr_off: assert property (p_thr_off) else $error("zero threshold left run gains");
   a_motion:  assert property (p_motion) else $error("motion did not force run gains");
   a_err_big: assert property (p_err_big) else $error("large error did not force run gains");
   a_db_zero: assert property (p_db_zero) else $error("deviation inside dead band not zeroed");
   a_db_pass: assert property (p_db_pass) else $error("deviation outside dead band altered");
endmodule // stf_tuning_chk
bind stf_tuning stf_tuning_chk u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .sample_i(sample_i),
   .pos_dev_i(pos_dev_i), .pos_dev_o(pos_dev_o), .dead_band_we_i(dead_band_we_i), .password_ok_i(password_ok_i),
   .dead_band_reject_o(dead_band_reject_o), .position_dead_band_o(position_dead_band_o),
   .gain_switch_threshold_i(gain_switch_threshold_i), .run_gains_i(run_gains_i), .motor_moving_i(motor_moving_i),
   .internal_motion_i(internal_motion_i), .pos_err_i(pos_err_i), .gains_o(gains_o),
   .gain_state_monitor_o(gain_state_monitor_o));

// >>> dv/test_stf_tuning.sv
`timescale 1ns/1ps
module test_stf_tuning;
   logic core_clk_i = 1'b0, nrst_i = 1'b0, sample_i = 1'b0, dead_band_we_i = 1'b0, password_ok_i = 1'b0;
   logic internal_motion_i = 1'b0, ext_pulse_i = 1'b0, dead_band_reject_o, gain_state_monitor_o, motor_moving_i;
   logic signed [23:0] torque_cmd_i = 24'sh0, torque_cmd_o, applied;
   logic signed [31:0] pos_dev_i = 32'sh0, pos_dev_o, pos_err_i, err_set = 32'sh5;
   logic [11:0] position_dead_band_i = 12'h000, position_dead_band_o;
   logic [21:0] gain_switch_threshold_i = 22'h000000;
   logic [16:0] gain_switch_delay_i = 17'h00000;
   stf_pkg::stf_filter_cfg_t filter_cfg_i = '0;
   stf_pkg::stf_gain_set_t run_gains_i = {10'h064, 15'h03e8}, stop_gains_i = {10'h014, 15'h012c}, gains_o;
   logic [1:0] scnt = 2'h0;
   int error_cnt = 0, comparisons = 0, cycles = 0;
   logic signed [31:0] dv [4] = '{32'sh2, -32'sh2, 32'sh3, -32'sh3};
   logic signed [31:0] dx [4] = '{32'sh0, 32'sh0, 32'sh3, -32'sh3};
   stf_tuning #(.DELAY_UNIT_CYCLES(10), .EXT_WINDOW_CYCLES(20)) i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .sample_i(sample_i), .torque_cmd_i(torque_cmd_i), .torque_cmd_o(torque_cmd_o), .filter_cfg_i(filter_cfg_i),
      .pos_dev_i(pos_dev_i), .pos_dev_o(pos_dev_o), .position_dead_band_i(position_dead_band_i),
      .dead_band_we_i(dead_band_we_i), .password_ok_i(password_ok_i), .dead_band_reject_o(dead_band_reject_o),
      .position_dead_band_o(position_dead_band_o), .gain_switch_threshold_i(gain_switch_threshold_i),
      .gain_switch_delay_i(gain_switch_delay_i), .run_gains_i(run_gains_i), .stop_gains_i(stop_gains_i),
      .motor_moving_i(motor_moving_i), .internal_motion_i(internal_motion_i), .ext_pulse_i(ext_pulse_i),
      .pos_err_i(pos_err_i), .gains_o(gains_o), .gain_state_monitor_o(gain_state_monitor_o));
   stf_drive_model u_drive (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .sample_i(sample_i),
      .torque_i(torque_cmd_o), .err_set_i(err_set), .pos_err_o(pos_err_i), .moving_o(motor_moving_i),
      .applied_o(applied));
   always #2 core_clk_i = ~core_clk_i;
   // One sample strobe every four clocks
   always @(negedge core_clk_i) begin
      scnt     <= scnt + 2'h1;
      sample_i <= (scnt == 2'h3);
   end
   // Whole run needs about 550 cycles
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic smp(input int n);
      repeat (n * 4) @(negedge core_clk_i);
   endtask
   task automatic db_write(input logic [11:0] v, input logic pw);
      position_dead_band_i = v;
      password_ok_i = pw;
      dead_band_we_i = 1'b1;
      @(negedge core_clk_i);
      dead_band_we_i = 1'b0;
      chk("reject", {31'h0, dead_band_reject_o}, {31'h0, !pw});
      @(negedge core_clk_i);
      chk("reject_end", {31'h0, dead_band_reject_o}, 32'h0);
   endtask
   task automatic gain_is(input logic run);
      chk("monitor", {31'h0, gain_state_monitor_o}, {31'h0, run});
      chk("gains", {7'h0, gains_o}, {7'h0, run ? run_gains_i : stop_gains_i});
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge core_clk_i);
      nrst_i = 1'b1;
      @(negedge core_clk_i);
      chk("reset_gains", {7'h0, gains_o}, {7'h0, stf_pkg::PGAIN_DEFAULT, stf_pkg::VGAIN_DEFAULT});
      chk("reset_db", {20'h0, position_dead_band_o}, 32'h0);
      chk("reset_torque", 32'(torque_cmd_o), 32'h0);
      torque_cmd_i = 24'sh3e8;
      smp(8);
      chk("bypass", 32'(torque_cmd_o), 32'h3e8);
      chk("applied", 32'(applied), 32'h3e8);
      // Two stages only, both above 100 Hz
      filter_cfg_i = '{10'h096, 10'h000, 10'h190, 9'h019, 10'h000, stf_pkg::Q_DEFAULT};
      torque_cmd_i = 24'sh4e20;
      smp(6);
      chk("lowpass_slow", {31'h0, torque_cmd_o < 24'sh4e20}, 32'h1);
      db_write(12'h006, 1'b0);
      smp(2);
      chk("db_refused", {20'h0, position_dead_band_o}, 32'h0);
      db_write(12'h006, 1'b1);
      smp(2);
      chk("db_taken", {20'h0, position_dead_band_o}, 32'h6);
      for (int i = 0; i < 4; i++) begin
         pos_dev_i = dv[i];
         smp(2);
         chk("dead_band", pos_dev_o, dx[i]);
      end
      smp(10);
      gain_is(1'b1);
      gain_switch_threshold_i = 22'h000064;
      smp(10);
      gain_is(1'b0);
      err_set = 32'shc8;
      smp(3);
      gain_is(1'b1);
      err_set = -32'sh5;
      smp(10);
      gain_is(1'b0);
      internal_motion_i = 1'b1;
      smp(3);
      gain_is(1'b1);
      internal_motion_i = 1'b0;
      smp(10);
      for (int i = 0; i < 12; i++) begin
         ext_pulse_i = 1'b1;
         @(negedge core_clk_i);
         ext_pulse_i = 1'b0;
         repeat (7) @(negedge core_clk_i);
      end
      gain_is(1'b1);
      smp(12);
      gain_is(1'b0);
      gain_switch_delay_i = 17'h00003;
      err_set = 32'shc8;
      smp(3);
      err_set = 32'sh5;
      smp(5);
      gain_is(1'b1);
      smp(20);
      gain_is(1'b0);
      tally_and_finish();
   end
endmodule // test_stf_tuning

// >>> rtl/stf_pkg.sv
// How it works
// - Filters sit between velocity loop and torque
// - Two low-pass stages, zero bypasses, 10..1000 Hz
// - Two notch stages, 40..1000 Hz, Q narrows
// - Deviation below dead band forced to zero
// - Dead band count equals half a pulse
// - Dead band change needs correct password
// - Zero threshold means run gains always
// - Stop gains when stopped and error small
// - Error held small longer than delay first
// - Motion pulses or pulse train force run
// - Pulse train under 10 kpps counts idle
// - Monitor shows 0 stop, 1 run gains
// - Gains clamped to their legal ranges
package stf_pkg;
   localparam int unsigned CLK_PERIOD_NS       = 4;
   localparam int unsigned DELAY_UNIT_NS       = 100000;  // 0.1 ms per delay count
   localparam int unsigned EXT_PULSE_PERIOD_NS = 100000;  // Period of 10 kpps
   localparam int unsigned DELAY_UNIT_CYCLES   = DELAY_UNIT_NS / CLK_PERIOD_NS;
   localparam int unsigned EXT_WINDOW_CYCLES   = EXT_PULSE_PERIOD_NS / CLK_PERIOD_NS;

   localparam logic [9:0]  LP_MIN_HZ    = 10'h00a;
   localparam logic [9:0]  NOTCH_MIN_HZ = 10'h028;
   localparam logic [9:0]  FILT_MAX_HZ  = 10'h3e8;
   localparam logic [8:0]  Q_MIN        = 9'h00a;       // 0.10
   localparam logic [8:0]  Q_MAX        = 9'h1f4;       // 5.00
   localparam logic [8:0]  Q_DEFAULT    = 9'h019;       // 0.25
   localparam logic [11:0] DEAD_BAND_DEFAULT = 12'h000;
   localparam logic [9:0]  PGAIN_MIN    = 10'h001;      // 0.01
   localparam logic [9:0]  PGAIN_MAX    = 10'h3e8;      // 10.00
   localparam logic [9:0]  PGAIN_DEFAULT = 10'h005;     // 0.05
   localparam logic [14:0] VGAIN_MIN    = 15'h000a;     // 0.10
   localparam logic [14:0] VGAIN_MAX    = 15'h639c;     // 255.00
   localparam logic [14:0] VGAIN_DEFAULT = 15'h0032;    // 0.50
   localparam logic [21:0] THRESH_MAX   = 22'h27ffff;   // 2621439 pulses
   localparam logic [16:0] DELAY_MAX    = 17'h186a0;    // 10000.0 ms

   localparam int unsigned COEF_FRAC   = 15;
   localparam int unsigned TWO_PI_Q15  = 205887;
   localparam logic [19:0] LP_DAMP     = 20'h0b505;     // sqrt(2) in Q15
   localparam int unsigned NOTCH_DAMP_NUM = 3276800;    // 100 * 2^15, Q in hundredths

   typedef struct packed {
      logic [9:0] lowpass_first_cutoff;
      logic [9:0] lowpass_second_cutoff;
      logic [9:0] notch_first_center;
      logic [8:0] notch_first_quality;
      logic [9:0] notch_second_center;
      logic [8:0] notch_second_quality;
   } stf_filter_cfg_t;

   typedef struct packed {
      logic [9:0]  position_gain;   // Hundredths
      logic [14:0] velocity_gain;   // Hundredths
   } stf_gain_set_t;

   typedef enum logic [1:0] {
      STF_RUN  = 2'b00,
      STF_HOLD = 2'b01,
      STF_STOP = 2'b11
   } stf_gain_state_t;
endpackage

// >>> rtl/stf_svf_stage.sv
`timescale 1ns/1ps
// State-variable section: low-pass or notch output, updated once per sample
module stf_svf_stage #(
   parameter int unsigned W   = 24,
   parameter int unsigned ACC = 28
) (
   input  wire logic                core_clk_i,   // Servo clock
   input  wire logic                nrst_i,       // Sync reset, active low
   input  wire logic                sample_i,     // Sample boundary strobe
   input  wire logic                bypass_i,     // Pass input straight through
   input  wire logic                notch_i,      // 1 notch, 0 low-pass
   input  wire logic [15:0]         freq_coef_i,  // Normalised frequency, Q15
   input  wire logic [19:0]         damp_i,       // Damping in Q15
   input  wire logic signed [W-1:0] x_i,          // Stage input
   output logic signed [W-1:0]      y_o           // Registered stage output
);
   logic signed [ACC-1:0] low_reg;
   logic signed [ACC-1:0] band_reg;
   logic signed [47:0]    f_s;
   logic signed [47:0]    q_s;
   logic signed [ACC-1:0] low_next;
   logic signed [ACC-1:0] high;
   logic signed [ACC-1:0] band_next;
   logic signed [ACC-1:0] sel;

   assign f_s       = 48'($signed({1'b0, freq_coef_i}));
   assign q_s       = 48'($signed({1'b0, damp_i}));
   assign low_next  = low_reg + ACC'((48'(band_reg) * f_s) >>> stf_pkg::COEF_FRAC);
   assign high      = ACC'(x_i) - low_next - ACC'((48'(band_reg) * q_s) >>> stf_pkg::COEF_FRAC);
   assign band_next = band_reg + ACC'((48'(high) * f_s) >>> stf_pkg::COEF_FRAC);
   // Notch is the sum of high and low paths; a wide damping widens the notch
   assign sel       = notch_i ? (high + low_next) : low_next;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i || bypass_i) begin
         // Bypassed stage holds zero state so it re-enters cleanly
         low_reg  <= '0;
         band_reg <= '0;
         if (!nrst_i)
            y_o <= '0;
         else if (sample_i)
            y_o <= x_i;
      end else if (sample_i) begin
         low_reg  <= low_next;
         band_reg <= band_next;
         y_o      <= W'(sel);
      end
   end
endmodule // stf_svf_stage

// >>> rtl/stf_tuning.sv
`timescale 1ns/1ps
module stf_tuning #(
   parameter int unsigned W                 = 24,
   parameter int unsigned SAMPLE_RATE_HZ    = 20000,
   parameter int unsigned DELAY_UNIT_CYCLES = stf_pkg::DELAY_UNIT_CYCLES,
   parameter int unsigned EXT_WINDOW_CYCLES = stf_pkg::EXT_WINDOW_CYCLES
) (
   input  wire logic                     core_clk_i,           // 250 MHz clock
   input  wire logic                     nrst_i,               // Sync reset, active low
   input  wire logic                     sample_i,             // Servo sample strobe
   input  wire logic signed [W-1:0]      torque_cmd_i,         // Velocity loop output
   output logic signed [W-1:0]           torque_cmd_o,         // Filtered torque
   input  wire stf_pkg::stf_filter_cfg_t filter_cfg_i,         // Filter settings
   input  wire logic signed [31:0]       pos_dev_i,            // Position loop deviation, pulses
   output logic signed [31:0]            pos_dev_o,            // Deviation after dead band
   input  wire logic [11:0]              position_dead_band_i, // New dead band, half pulses
   input  wire logic                     dead_band_we_i,       // Dead band write strobe
   input  wire logic                     password_ok_i,        // Password entered
   output logic                          dead_band_reject_o,   // Write refused, pulse
   output logic [11:0]                   position_dead_band_o, // Dead band in force
   input  wire logic [21:0]              gain_switch_threshold_i, // Pulses, 0 disables
   input  wire logic [16:0]              gain_switch_delay_i,  // 0.1 ms units
   input  wire stf_pkg::stf_gain_set_t   run_gains_i,          // Gains for operation
   input  wire stf_pkg::stf_gain_set_t   stop_gains_i,         // Gains for stopping
   input  wire logic                     motor_moving_i,       // Motor not stopped
   input  wire logic                     internal_motion_i,    // Internal pulses generated
   input  wire logic                     ext_pulse_i,          // External pulse train
   input  wire logic signed [31:0]       pos_err_i,            // Position error, pulses
   output stf_pkg::stf_gain_set_t        gains_o,              // Gains in force
   output logic                          gain_state_monitor_o  // 1 run, 0 stop
);
   localparam int unsigned FREQ_SCALE = stf_pkg::TWO_PI_Q15 / SAMPLE_RATE_HZ;

   function automatic logic [9:0] clamp_hz(input logic [9:0] v, input logic [9:0] lo);
      if (v < lo)
         return lo;
      else if (v > stf_pkg::FILT_MAX_HZ)
         return stf_pkg::FILT_MAX_HZ;
      return v;
   endfunction

   function automatic logic [15:0] freq_coef(input logic [9:0] hz);
      return 16'(32'(hz) * FREQ_SCALE);
   endfunction

   function automatic logic [19:0] notch_damp(input logic [8:0] q);
      logic [8:0] qc;
      qc = (q < stf_pkg::Q_MIN) ? stf_pkg::Q_MIN : ((q > stf_pkg::Q_MAX) ? stf_pkg::Q_MAX : q);
      return 20'(stf_pkg::NOTCH_DAMP_NUM / 32'(qc));
   endfunction

   function automatic stf_pkg::stf_gain_set_t clamp_gain(input stf_pkg::stf_gain_set_t g);
      stf_pkg::stf_gain_set_t r;
      r = g;
      if (g.position_gain < stf_pkg::PGAIN_MIN) r.position_gain = stf_pkg::PGAIN_MIN;
      if (g.position_gain > stf_pkg::PGAIN_MAX) r.position_gain = stf_pkg::PGAIN_MAX;
      if (g.velocity_gain < stf_pkg::VGAIN_MIN) r.velocity_gain = stf_pkg::VGAIN_MIN;
      if (g.velocity_gain > stf_pkg::VGAIN_MAX) r.velocity_gain = stf_pkg::VGAIN_MAX;
      return r;
   endfunction

   // Shadow settings, swapped only at a sample boundary
   stf_pkg::stf_filter_cfg_t cfg_reg;
   stf_pkg::stf_gain_set_t   run_reg;
   stf_pkg::stf_gain_set_t   stop_reg;
   logic [11:0]              dead_band_pend_reg;

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         cfg_reg  <= '{10'h000, 10'h000, 10'h000, stf_pkg::Q_DEFAULT, 10'h000, stf_pkg::Q_DEFAULT};
         run_reg  <= '{stf_pkg::PGAIN_DEFAULT, stf_pkg::VGAIN_DEFAULT};
         stop_reg <= '{stf_pkg::PGAIN_DEFAULT, stf_pkg::VGAIN_DEFAULT};
      end else if (sample_i) begin
         cfg_reg  <= filter_cfg_i;
         run_reg  <= clamp_gain(run_gains_i);
         stop_reg <= clamp_gain(stop_gains_i);
      end
   end

   // Filter chain: two low-pass then two notch sections
   logic [3:0]        st_bypass;
   logic [3:0]        st_notch;
   logic [9:0]        st_hz   [4];
   logic [19:0]       st_damp [4];
   logic signed [W-1:0] chain [5];

   assign st_hz[0]   = cfg_reg.lowpass_first_cutoff;
   assign st_hz[1]   = cfg_reg.lowpass_second_cutoff;
   assign st_hz[2]   = cfg_reg.notch_first_center;
   assign st_hz[3]   = cfg_reg.notch_second_center;
   assign st_notch   = 4'hc;
   assign st_damp[0] = stf_pkg::LP_DAMP;
   assign st_damp[1] = stf_pkg::LP_DAMP;
   assign st_damp[2] = notch_damp(cfg_reg.notch_first_quality);
   assign st_damp[3] = notch_damp(cfg_reg.notch_second_quality);
   assign chain[0]   = torque_cmd_i;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_stage
         logic [9:0] hz_c;
         assign st_bypass[gi] = (st_hz[gi] == 10'h000);
         assign hz_c = clamp_hz(st_hz[gi], st_notch[gi] ? stf_pkg::NOTCH_MIN_HZ : stf_pkg::LP_MIN_HZ);
         stf_svf_stage #(.W(W), .ACC(W + 4)) u_stage (
            .core_clk_i  (core_clk_i),
            .nrst_i      (nrst_i),
            .sample_i    (sample_i),
            .bypass_i    (st_bypass[gi]),
            .notch_i     (st_notch[gi]),
            .freq_coef_i (freq_coef(hz_c)),
            .damp_i      (st_damp[gi]),
            .x_i         (chain[gi]),
            .y_o         (chain[gi+1])
         );
      end
   endgenerate

   assign torque_cmd_o = chain[4];

   // Dead band: write accepted only with password, applied next sample
   logic        db_accept;
   logic [32:0] dev_abs_x2;
   logic        in_band;

   assign db_accept  = dead_band_we_i && password_ok_i;
   assign dev_abs_x2 = {(pos_dev_i[31] ? 32'(-pos_dev_i) : 32'(pos_dev_i)), 1'b0};
   assign in_band    = dev_abs_x2 < 33'(position_dead_band_o);

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         dead_band_pend_reg   <= stf_pkg::DEAD_BAND_DEFAULT;
         position_dead_band_o <= stf_pkg::DEAD_BAND_DEFAULT;
         dead_band_reject_o   <= 1'b0;
         pos_dev_o            <= '0;
      end else begin
         dead_band_reject_o <= dead_band_we_i && !password_ok_i;
         if (db_accept)
            dead_band_pend_reg <= position_dead_band_i;
         if (sample_i) begin
            position_dead_band_o <= db_accept ? position_dead_band_i : dead_band_pend_reg;
            pos_dev_o            <= in_band ? '0 : pos_dev_i;
         end
      end
   end

   // External pulse train seen within the last 100 us means above 10 kpps
   localparam int unsigned EXT_CW = $clog2(EXT_WINDOW_CYCLES + 1);
   logic              ext_prev_reg;
   logic [EXT_CW-1:0] ext_gap_reg;
   logic              ext_active;

   assign ext_active = ext_gap_reg < EXT_CW'(EXT_WINDOW_CYCLES);

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ext_prev_reg <= 1'b0;
         ext_gap_reg  <= EXT_CW'(EXT_WINDOW_CYCLES);
      end else begin
         ext_prev_reg <= ext_pulse_i;
         if (ext_pulse_i && !ext_prev_reg)
            ext_gap_reg <= '0;
         else if (ext_active)
            ext_gap_reg <= ext_gap_reg + 1'b1;
      end
   end

   // Gain switching state machine
   localparam int unsigned TICK_CW = $clog2(DELAY_UNIT_CYCLES + 1);
   stf_pkg::stf_gain_state_t st_reg;
   stf_pkg::stf_gain_state_t st_next;
   logic [TICK_CW-1:0]       tick_cnt_reg;
   logic [17:0]              hold_cnt_reg;
   logic                     tick;
   logic                     force_run;
   logic                     err_small;
   logic [31:0]              err_abs;
   logic [21:0]              thresh;

   assign thresh    = (gain_switch_threshold_i > stf_pkg::THRESH_MAX) ? stf_pkg::THRESH_MAX
                                                                      : gain_switch_threshold_i;
   assign err_abs   = pos_err_i[31] ? 32'(-pos_err_i) : 32'(pos_err_i);
   assign err_small = err_abs < 32'(thresh);
   assign force_run = (thresh == 22'h000000) || motor_moving_i
                      || internal_motion_i || ext_active || !err_small;
   assign tick      = tick_cnt_reg == TICK_CW'(DELAY_UNIT_CYCLES - 1);

   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         stf_pkg::STF_RUN:
            if (!force_run)
               st_next = (gain_switch_delay_i == 17'h00000) ? stf_pkg::STF_STOP : stf_pkg::STF_HOLD;
         stf_pkg::STF_HOLD:
            if (force_run)
               st_next = stf_pkg::STF_RUN;
            else if (hold_cnt_reg > 18'(gain_switch_delay_i))
               st_next = stf_pkg::STF_STOP;
         stf_pkg::STF_STOP:
            if (force_run)
               st_next = stf_pkg::STF_RUN;
         default:
            st_next = stf_pkg::STF_RUN;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         st_reg       <= stf_pkg::STF_RUN;
         tick_cnt_reg <= '0;
         hold_cnt_reg <= '0;
      end else begin
         st_reg <= st_next;
         // Hold timing restarts each time the hold phase is entered
         if (st_reg != stf_pkg::STF_HOLD) begin
            tick_cnt_reg <= '0;
            hold_cnt_reg <= '0;
         end else begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
            if (tick && hold_cnt_reg != 18'h3ffff)
               hold_cnt_reg <= hold_cnt_reg + 1'b1;
         end
      end
   end

   // Gains change only at sample boundary so loops see a consistent pair
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         gains_o              <= '{stf_pkg::PGAIN_DEFAULT, stf_pkg::VGAIN_DEFAULT};
         gain_state_monitor_o <= 1'b1;
      end else if (sample_i) begin
         gains_o              <= (st_reg == stf_pkg::STF_STOP) ? stop_reg : run_reg;
         gain_state_monitor_o <= st_reg != stf_pkg::STF_STOP;
      end
   end
endmodule // stf_tuning
